/* File: etc_pkg.sv */
// Package: constants, register map and types of the edge trigger controller
// Function
// RL1: Up to 21 edge channels, each giving an interrupt request and an event.
// RL2: Each channel triggers on rising, falling or both edges.
// RL3: Trigger setup and masking are per channel, channels never interfere.
// RL4: Sources are 16 pin lines plus 5 internal module lines.
// RL5: Pin line n takes pin n of the port picked by its source select.
// RL6: Lines 16,17,19,21,25 take detector, alarm, tamper, comparator, serial wakeup.
// RL7: Event pulses let the core leave wait-for-event without an interrupt.
// RL8: Any enabled trigger raises a wakeup toward the system.
// RL9: A software trigger takes the same path as a detected edge.
// RL10: The low-voltage detector line drives interrupt request 1 (vector 17).
// RL11: Pending flag sets on trigger, cleared only by writing 1.
// RL12: Interrupt-enable bit gates each line's interrupt request.
// RL13: Event-enable bit gates each line's event pulse.
// RL14: Rise and fall enables make that edge valid; disabled edges ignored.
// RL15: Inputs are sampled, edge found by comparing with previous sample.
// RL16: Line request is high while pending flag and interrupt enable are set.
package etc_pkg;
  localparam int          ETC_LINES      = 28;
  localparam int          ETC_PINS       = 16;
  localparam int          ETC_PORTS      = 4;
  localparam int          ETC_SEL_W      = 2;
  localparam int          ETC_AW         = 4;
  // Line numbers of the internal sources
  localparam int          ETC_LN_LOW_V   = 16;
  localparam int          ETC_LN_ALARM   = 17;
  localparam int          ETC_LN_TAMPER  = 19;
  localparam int          ETC_LN_COMP    = 21;
  localparam int          ETC_LN_UART    = 25;
  // Lines that carry a source at all
  localparam logic [27:0] ETC_USED_MASK  = 28'h22BFFFF;
  // Register word offsets (word address)
  localparam logic [ETC_AW-1:0] ETC_A_IRQ_EN = 4'h0;
  localparam logic [ETC_AW-1:0] ETC_A_EVT_EN = 4'h1;
  localparam logic [ETC_AW-1:0] ETC_A_RISE   = 4'h2;
  localparam logic [ETC_AW-1:0] ETC_A_FALL   = 4'h3;
  localparam logic [ETC_AW-1:0] ETC_A_SOFT   = 4'h4;
  localparam logic [ETC_AW-1:0] ETC_A_PEND   = 4'h5;
  localparam logic [ETC_AW-1:0] ETC_A_SRC    = 4'h6;
  localparam logic [27:0] ETC_IRQEN_RST  = 28'hF940000;
  localparam logic [31:0] ETC_ZERO32     = 32'h00000000;
  localparam logic [31:0] ETC_UNMAPPED   = 32'hDEADBEEF;
  typedef enum logic [1:0] {
    ETC_BUS_IDLE = 2'b00,
    ETC_BUS_ACK  = 2'b01
  } etc_bus_state_t;
endpackage : etc_pkg

/* File: etc_edge.sv */
// Per-line sampler and edge finder
`timescale 1ns/1ps
module etc_edge (
  input  wire logic                         i_clk,
  input  wire logic                         i_rst,
  input  wire logic [etc_pkg::ETC_LINES-1:0] i_line,
  input  wire logic [etc_pkg::ETC_LINES-1:0] i_rise_en,
  input  wire logic [etc_pkg::ETC_LINES-1:0] i_fall_en,
  output logic      [etc_pkg::ETC_LINES-1:0] o_edge
);
  logic [etc_pkg::ETC_LINES-1:0] sample;
  logic [etc_pkg::ETC_LINES-1:0] prev;
  // Inputs are synchronous; one sample plus its predecessor suffices
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sample <= '0;
      prev   <= '0;
    end else begin
      sample <= i_line;  // see RL15
      prev   <= sample;
    end
  end
  // Independent per line, so one line's setup cannot touch another
  genvar g;
  generate
    for (g = 0; g < etc_pkg::ETC_LINES; g++) begin : g_line
      assign o_edge[g] = (i_rise_en[g] & sample[g] & ~prev[g]) |   // see RL14 see RL2 see RL3
                         (i_fall_en[g] & ~sample[g] & prev[g]);    // see RL14 see RL2
    end
  endgenerate
endmodule : etc_edge

/* File: etc_pinmux.sv */
// Pin line source selection
`timescale 1ns/1ps
module etc_pinmux (
  input  wire logic [etc_pkg::ETC_PORTS*etc_pkg::ETC_PINS-1:0] i_port_pins,
  input  wire logic [etc_pkg::ETC_PINS*etc_pkg::ETC_SEL_W-1:0] i_sel,
  output logic      [etc_pkg::ETC_PINS-1:0]                    o_pin_line
);
  // Line n always sees pin n, only the port varies
  genvar g;
  generate
    for (g = 0; g < etc_pkg::ETC_PINS; g++) begin : g_pin
      logic [etc_pkg::ETC_SEL_W-1:0] s;
      assign s = i_sel[g*etc_pkg::ETC_SEL_W +: etc_pkg::ETC_SEL_W];
      assign o_pin_line[g] = i_port_pins[32'(s)*etc_pkg::ETC_PINS + g];  // see RL5
    end
  endgenerate
endmodule : etc_pinmux

/* File: etc_top.sv */
// Edge trigger controller top: Avalon-MM slave, pending flags, outputs
//
// The implementer's own choices: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
module etc_top (
  input  wire logic                                         i_clk,
  input  wire logic                                         i_rst,
  // Avalon-MM slave, word address
  input  wire logic [etc_pkg::ETC_AW-1:0]                   i_avs_address,
  input  wire logic                                         i_avs_read,
  input  wire logic                                         i_avs_write,
  input  wire logic [31:0]                                  i_avs_writedata,
  input  wire logic [3:0]                                   i_avs_byteenable,
  output logic      [31:0]                                  o_avs_readdata,
  output logic                                              o_avs_waitrequest,
  // Trigger sources
  input  wire logic [etc_pkg::ETC_PORTS*etc_pkg::ETC_PINS-1:0] i_port_pins,
  input  wire logic                                         i_low_voltage_detector,
  input  wire logic                                         i_clock_alarm,
  input  wire logic                                         i_clock_tamper,
  input  wire logic                                         i_analog_comparator,
  input  wire logic                                         i_serial_wakeup,
  // Toward the core
  output logic      [etc_pkg::ETC_LINES-1:0]                o_line_irq,
  output logic      [etc_pkg::ETC_LINES-1:0]                o_line_event,
  output logic                                              o_low_voltage_irq,
  output logic                                              o_event,
  output logic                                              o_wakeup,
  output logic                                              o_irq
);
  localparam int N = etc_pkg::ETC_LINES;

  logic [N-1:0]  line_irq_enable;
  logic [N-1:0]  line_event_enable;
  logic [N-1:0]  line_rise_enable;
  logic [N-1:0]  line_fall_enable;
  logic [N-1:0]  line_pending_flag;
  logic [31:0]   pin_line_source_select;
  logic [N-1:0]  raw_lines;
  logic [15:0]   pin_lines;
  logic [N-1:0]  hw_edge;
  logic [N-1:0]  soft_pulse;
  logic [N-1:0]  trig;
  logic [N-1:0]  pend_clear;
  logic [N-1:0]  event_q;
  logic [31:0]   wmask;
  logic          wr_go;
  logic [31:0]   read_word;
  etc_pkg::etc_bus_state_t bus_state;

  // Port selection for the sixteen pin lines
  etc_pinmux u_pinmux (
    .i_port_pins (i_port_pins),
    .i_sel       (pin_line_source_select),
    .o_pin_line  (pin_lines)
  );

  // Assemble all lines; unused positions are held low
  always_comb begin
    raw_lines = '0;
    raw_lines[etc_pkg::ETC_PINS-1:0]   = pin_lines;               // see RL4
    raw_lines[etc_pkg::ETC_LN_LOW_V]   = i_low_voltage_detector;  // see RL6
    raw_lines[etc_pkg::ETC_LN_ALARM]   = i_clock_alarm;           // see RL6
    raw_lines[etc_pkg::ETC_LN_TAMPER]  = i_clock_tamper;          // see RL6
    raw_lines[etc_pkg::ETC_LN_COMP]    = i_analog_comparator;     // see RL6
    raw_lines[etc_pkg::ETC_LN_UART]    = i_serial_wakeup;         // see RL6
  end

  etc_edge u_edge (
    .i_clk     (i_clk),
    .i_rst     (i_rst),
    .i_line    (raw_lines),
    .i_rise_en (line_rise_enable),
    .i_fall_en (line_fall_enable),
    .o_edge    (hw_edge)
  );

  // Bus: every access answers one cycle after it is first seen
  assign wr_go = i_avs_write & (bus_state == etc_pkg::ETC_BUS_ACK);
  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & (bus_state != etc_pkg::ETC_BUS_ACK);
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      bus_state <= etc_pkg::ETC_BUS_IDLE;
    end else begin
      case (bus_state)
        etc_pkg::ETC_BUS_IDLE: begin
          if (i_avs_read | i_avs_write) begin
            bus_state <= etc_pkg::ETC_BUS_ACK;
          end
        end
        etc_pkg::ETC_BUS_ACK: begin
          bus_state <= etc_pkg::ETC_BUS_IDLE;
        end
        default: begin
          bus_state <= etc_pkg::ETC_BUS_IDLE;
        end
      endcase
    end
  end

  // Byte lanes expand to a bit mask
  always_comb begin
    wmask = '0;
    for (int b = 0; b < 4; b++) begin
      wmask[b*8 +: 8] = {8{i_avs_byteenable[b]}};
    end
  end

  // Configuration registers; only the rise and fall enables keep bits of unused lines zero
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      line_irq_enable        <= etc_pkg::ETC_IRQEN_RST;
      line_event_enable      <= '0;
      line_rise_enable       <= '0;
      line_fall_enable       <= '0;
      pin_line_source_select <= etc_pkg::ETC_ZERO32;
    end else if (wr_go) begin
      case (i_avs_address)
        etc_pkg::ETC_A_IRQ_EN: begin
          line_irq_enable <= (line_irq_enable & ~wmask[N-1:0]) | (i_avs_writedata[N-1:0] & wmask[N-1:0]);
        end
        etc_pkg::ETC_A_EVT_EN: begin
          line_event_enable <= (line_event_enable & ~wmask[N-1:0]) | (i_avs_writedata[N-1:0] & wmask[N-1:0]);
        end
        etc_pkg::ETC_A_RISE: begin
          line_rise_enable <= ((line_rise_enable & ~wmask[N-1:0]) | (i_avs_writedata[N-1:0] & wmask[N-1:0]))
                              & etc_pkg::ETC_USED_MASK;
        end
        etc_pkg::ETC_A_FALL: begin
          line_fall_enable <= ((line_fall_enable & ~wmask[N-1:0]) | (i_avs_writedata[N-1:0] & wmask[N-1:0]))
                              & etc_pkg::ETC_USED_MASK;
        end
        etc_pkg::ETC_A_SRC: begin
          pin_line_source_select <= (pin_line_source_select & ~wmask) | (i_avs_writedata & wmask);
        end
        default: begin
        end
      endcase
    end
  end

  // Soft trigger register bits act as a one-cycle pulse and read back zero
  always_comb begin
    soft_pulse = '0;
    pend_clear = '0;
    if (wr_go && i_avs_address == etc_pkg::ETC_A_SOFT) begin
      soft_pulse = i_avs_writedata[N-1:0] & wmask[N-1:0] & etc_pkg::ETC_USED_MASK;  // see RL9
    end
    if (wr_go && i_avs_address == etc_pkg::ETC_A_PEND) begin
      pend_clear = i_avs_writedata[N-1:0] & wmask[N-1:0];  // see RL11
    end
  end

  // Hardware and software triggers share one path
  assign trig = hw_edge | soft_pulse;  // see RL9 see RL1

  // Pending flags: a new trigger wins over a clear in the same cycle
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      line_pending_flag <= '0;
    end else begin
      line_pending_flag <= (line_pending_flag & ~pend_clear) | trig;  // see RL11 see RL15
    end
  end

  // Event pulses, one cycle per trigger
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      event_q <= '0;
    end else begin
      event_q <= trig & line_event_enable;  // see RL13 see RL15 see RL7
    end
  end

  // Read mux; unmapped words return a marker so stray reads are visible
  always_comb begin
    read_word = etc_pkg::ETC_ZERO32;
    case (i_avs_address)
      etc_pkg::ETC_A_IRQ_EN: read_word = {4'h0, line_irq_enable};
      etc_pkg::ETC_A_EVT_EN: read_word = {4'h0, line_event_enable};
      etc_pkg::ETC_A_RISE:   read_word = {4'h0, line_rise_enable};
      etc_pkg::ETC_A_FALL:   read_word = {4'h0, line_fall_enable};
      etc_pkg::ETC_A_SOFT:   read_word = etc_pkg::ETC_ZERO32;
      etc_pkg::ETC_A_PEND:   read_word = {4'h0, line_pending_flag};
      etc_pkg::ETC_A_SRC:    read_word = pin_line_source_select;
      default:               read_word = etc_pkg::ETC_UNMAPPED;
    endcase
  end

  // Read data captured in the wait cycle, shown in the ack cycle, zero otherwise
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_avs_readdata <= etc_pkg::ETC_ZERO32;
    end else if (i_avs_read && bus_state == etc_pkg::ETC_BUS_IDLE) begin
      o_avs_readdata <= read_word;
    end else begin
      o_avs_readdata <= etc_pkg::ETC_ZERO32;
    end
  end

  // Outputs toward the core
  assign o_line_irq   = line_pending_flag & line_irq_enable;              // see RL16 see RL12
  assign o_line_event = event_q;                                          // see RL7
  assign o_low_voltage_irq = o_line_irq[etc_pkg::ETC_LN_LOW_V];           // see RL10
  assign o_event      = |event_q;                                         // see RL7
  assign o_irq        = |o_line_irq;
  // Wakeup follows any enabled request, irq level or event pulse
  assign o_wakeup     = (|o_line_irq) | (|event_q);                       // see RL8
endmodule : etc_top

/* File: etc_top_properties.sv */
// Checker of the edge trigger controller port behaviour
`timescale 1ns/1ps
module etc_top_checker (
  input wire logic        i_clk,
  input wire logic        i_rst,
  input wire logic [3:0]  i_avs_address,
  input wire logic        i_avs_read,
  input wire logic        i_avs_write,
  input wire logic [31:0] o_avs_readdata,
  input wire logic        o_avs_waitrequest,
  input wire logic [27:0] o_line_irq,
  input wire logic [27:0] o_line_event,
  input wire logic        o_low_voltage_irq,
  input wire logic        o_event,
  input wire logic        o_wakeup,
  input wire logic        o_irq
);
  // One clock domain, so clocking and disable are given once
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // Summary outputs must track the per-line vectors in the same cycle
  a_irq_any_line: assert property (o_irq == |o_line_irq) else $error("irq not OR of lines");
  a_low_irq_map: assert property (o_low_voltage_irq == o_line_irq[16]) else $error("low irq not line 16");
  a_wake_follows: assert property (o_wakeup == (o_irq | o_event)) else $error("wakeup mismatch");
  a_event_any_line: assert property (o_event == |o_line_event) else $error("event not OR of lines");
  // Lines with no source never pulse
  a_unused_quiet: assert property ((o_line_event & ~etc_pkg::ETC_USED_MASK) == 28'h0000000)
    else $error("event on unused line");
  // Exactly one wait cycle per access
  a_one_wait: assert property ((i_avs_read | i_avs_write) & o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("second wait cycle");
  // Read data stands only in the acknowledged read cycle
  a_read_idle_zero: assert property (!(i_avs_read && !o_avs_waitrequest) |-> o_avs_readdata == 32'h00000000)
    else $error("read data outside ack cycle");
  a_unmapped_mark: assert property (i_avs_read && !o_avs_waitrequest && i_avs_address > 4'h6 |->
    o_avs_readdata == 32'hDEADBEEF) else $error("unmapped read not marked");
  a_reset_quiet: assert property ($fell(i_rst) |-> !o_irq && !o_event) else $error("busy after reset");
  // Without a write no request may drop: flags are sticky
  a_flag_sticky: assert property (!i_avs_write |=> (o_line_irq & $past(o_line_irq)) == $past(o_line_irq))
    else $error("request dropped without write");
endmodule : etc_top_checker
bind etc_top etc_top_checker etc_top_checker_inst (.i_clk(i_clk), .i_rst(i_rst), .i_avs_address(i_avs_address),
  .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .o_avs_readdata(o_avs_readdata),
  .o_avs_waitrequest(o_avs_waitrequest), .o_line_irq(o_line_irq), .o_line_event(o_line_event),
  .o_low_voltage_irq(o_low_voltage_irq), .o_event(o_event), .o_wakeup(o_wakeup), .o_irq(o_irq));

/* File: etc_core_model.sv */
// Core side model: counts event pulses and latches wakeups
`timescale 1ns/1ps
module etc_core_model (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_event,
  input  wire logic       i_wakeup,
  output logic      [7:0] o_events,
  output logic            o_woken
);
  // Each one-cycle pulse is one exit from wait-for-event
  always_ff @(posedge i_clk) begin
    if (i_rst) o_events <= 8'h00;
    else if (i_event) o_events <= o_events + 8'h01;
  end
  // Latched, since a sleeping core may miss a short pulse
  always_ff @(posedge i_clk) begin
    o_woken <= i_rst ? 1'b0 : (o_woken | i_wakeup);
  end
endmodule : etc_core_model

/* File: etc_top_bench.sv */
// Self-checking bench of the edge trigger controller
`timescale 1ns/1ps
module etc_top_bench;
  logic        i_clk = 1'b0;
  logic        i_rst = 1'b1;
  logic [3:0]  adr = 4'h0;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wd = 32'h00000000;
  logic [63:0] pins = 64'h0000000000000000;
  logic        low_v = 1'b0;
  logic        comp = 1'b0;
  logic        src_off = 1'b0;
  logic [31:0] rdat, q;
  logic        wreq, low_irq, ev, wake, irq, woken;
  logic [27:0] lirq, lev;
  logic [7:0]  evs;
  int          miscompares = 0;
  int          n_compared = 0;
  // 50 MHz system clock
  always #10 i_clk = ~i_clk;
  etc_top etc_top_inst (.i_clk(i_clk), .i_rst(i_rst), .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wd), .i_avs_byteenable(4'hF), .o_avs_readdata(rdat), .o_avs_waitrequest(wreq),
    .i_port_pins(pins), .i_low_voltage_detector(low_v), .i_clock_alarm(src_off), .i_clock_tamper(src_off),
    .i_analog_comparator(comp), .i_serial_wakeup(src_off), .o_line_irq(lirq), .o_line_event(lev),
    .o_low_voltage_irq(low_irq), .o_event(ev), .o_wakeup(wake), .o_irq(irq));
  etc_core_model etc_core_model_inst (.i_clk(i_clk), .i_rst(i_rst), .i_event(ev), .i_wakeup(wake),
    .o_events(evs), .o_woken(woken));
  task automatic wrap_up;
    if (miscompares == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : wrap_up
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  // One access; request held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    @(posedge i_clk);
    adr <= a;
    wr <= w;
    rd <= !w;
    wd <= d;
    for (n = 0; n < 20; n++) begin
      @(posedge i_clk);
      if (wreq === 1'b0) break;
    end
    if (n == 20) begin
      miscompares++;
      wrap_up();
    end
    r = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus
  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    bus(1'b1, a, d, q);
  endtask : wreg
  task automatic rchk(input string s, input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h00000000, q);
    chk(s, e, q);
  endtask : rchk
  task automatic t_reset;
    rchk("irq enable", 4'h0, 32'h0F940000);
    rchk("pend", 4'h5, 32'h00000000);
    rchk("unmapped", 4'hF, 32'hDEADBEEF);
    chk("irq", 32'h0, {31'h0, irq});
  endtask : t_reset
  // Line 3 from port 2; the same pin of port 0 must not reach it
  task automatic t_pin;
    wreg(4'h6, 32'h00000080);
    wreg(4'h2, 32'h00000008);
    wreg(4'h0, 32'h0F940008);
    wreg(4'h1, 32'h00000008);
    @(posedge i_clk) pins[3] <= 1'b1;
    repeat (4) @(posedge i_clk);
    rchk("pend unselected", 4'h5, 32'h00000000);
    @(posedge i_clk) pins[35] <= 1'b1;
    repeat (4) @(posedge i_clk);
    rchk("pend pin", 4'h5, 32'h00000008);
    chk("line irq", 32'h00000008, {4'h0, lirq});
    chk("events", 32'h1, {24'h0, evs});
    @(posedge i_clk) pins[35] <= 1'b0;
    repeat (4) @(posedge i_clk);
    wreg(4'h5, 32'h00000000);
    rchk("pend kept", 4'h5, 32'h00000008);
    wreg(4'h5, 32'h00000008);
    rchk("pend cleared", 4'h5, 32'h00000000);
    chk("irq off", 32'h0, {31'h0, irq});
  endtask : t_pin
  // Both edges on the comparator line, falling only on the detector line
  task automatic t_edges;
    wreg(4'h2, 32'h00200000);
    wreg(4'h3, 32'h00210000);
    wreg(4'h1, 32'h00200000);
    @(posedge i_clk) low_v <= 1'b1;
    comp <= 1'b1;
    repeat (4) @(posedge i_clk);
    rchk("pend rise", 4'h5, 32'h00200000);
    @(posedge i_clk) low_v <= 1'b0;
    comp <= 1'b0;
    repeat (4) @(posedge i_clk);
    rchk("pend fall", 4'h5, 32'h00210000);
    chk("events", 32'h3, {24'h0, evs});
    chk("low voltage masked", 32'h0, {31'h0, low_irq});
    wreg(4'h0, 32'h0F950008);
    @(negedge i_clk);
    chk("low voltage irq", 32'h1, {31'h0, low_irq});
  endtask : t_edges
  // Soft trigger on a masked line and on an unused line
  task automatic t_soft;
    wreg(4'h5, 32'h0FFFFFFF);
    wreg(4'h4, 32'h000C0000);
    rchk("pend soft", 4'h5, 32'h00080000);
    chk("irq masked", 32'h0, {31'h0, irq});
    wreg(4'h0, 32'h0F9D0008);
    @(negedge i_clk);
    chk("irq soft", 32'h1, {31'h0, irq});
    chk("woken", 32'h1, {31'h0, woken});
  endtask : t_soft
  initial begin
    repeat (16) @(posedge i_clk);
    i_rst <= 1'b0;
    t_reset();
    t_pin();
    t_edges();
    t_soft();
    wrap_up();
  end
endmodule : etc_top_bench
